// ===== rtl/o3cr_pkg.sv
package o3cr_pkg;
	localparam logic [7:0] O3CR_DRV_CTRL_ADDR = 8'h2b;
	localparam logic [7:0] O3CR_SE_CTRL_ADDR = 8'h2c;
	localparam logic [7:0] O3CR_DRV_CTRL_RESET = 8'h14;
	localparam logic [7:0] O3CR_SE_CTRL_RESET = 8'h00;
	localparam logic [7:0] O3CR_DRV_CTRL_WMASK = 8'hfe;
	localparam logic [7:0] O3CR_SE_CTRL_WMASK = 8'hfc;

	typedef enum logic [1:0] {
		O3CR_POL_FORCE_HIGH = 2'b00,
		O3CR_POL_PASS = 2'b01,
		O3CR_POL_INVERT = 2'b10,
		O3CR_POL_FORCE_LOW = 2'b11
	} o3cr_pol_type;

	typedef enum logic [2:0] {
		O3CR_STD_LVDS_HALF = 3'b000,
		O3CR_STD_LVDS_3Q = 3'b001,
		O3CR_STD_LVDS_FULL = 3'b010,
		O3CR_STD_LVDS_125 = 3'b011,
		O3CR_STD_HSTL = 3'b100,
		O3CR_STD_HSTL_BOOST = 3'b101,
		O3CR_STD_HIZ_A = 3'b110,
		O3CR_STD_HIZ_B = 3'b111
	} o3cr_std_type;

	typedef struct packed {
		logic divider_three_powerdown;
		logic divider_three_sync_exclude;
		o3cr_pol_type diff_driver_polarity;
		o3cr_std_type diff_driver_standard;
		logic reserved0;
	} o3cr_drv_type;

	typedef struct packed {
		logic true_side_cmos_enable;
		o3cr_pol_type true_side_cmos_polarity;
		logic comp_side_cmos_enable;
		o3cr_pol_type comp_side_cmos_polarity;
		logic [1:0] reserved10;
	} o3cr_se_type;

	typedef struct packed {
		logic lvds_active;
		logic hstl_active;
		logic hiz_cmos;
		logic [1:0] current_level;
		logic hstl_boost;
	} o3cr_std_dec_type;
endpackage : o3cr_pkg

// ===== rtl/o3cr_polarity.sv
`timescale 1ns/1ps
module o3cr_polarity
	import o3cr_pkg::*;
(
	input wire logic clk_div,
	input wire o3cr_pol_type pol,
	output logic pin_level
);
	always_comb begin
		unique case (pol)
			O3CR_POL_FORCE_HIGH: pin_level = 1'b1;
			O3CR_POL_PASS: pin_level = clk_div;
			O3CR_POL_INVERT: pin_level = ~clk_div;
			O3CR_POL_FORCE_LOW: pin_level = 1'b0;
		endcase
	end
endmodule : o3cr_polarity

// ===== rtl/o3cr_output3_control_regs.sv
`timescale 1ns/1ps
// Contract
// - With the sync-exclude bit set, an output synchronization leaves the divider untouched.
// - The sync-exclude bit resets to 0 so the divider joins every synchronization.
// - Differential polarity 00 forces high, 01 passes, 10 inverts, 11 forces low.
// - Standard codes 000-011 are LVDS levels, 100 HSTL, 101 boosted HSTL, 110/111 high-Z/CMOS.
// - The true-side CMOS driver is on when its enable is set and resets off.
// - True-side CMOS polarity uses the same four codes and resets to force high.
// - The complement-side CMOS driver is on when its enable is set and resets off.
// - Complement-side CMOS polarity uses the same four codes and resets to force high.
module o3cr_output3_control_regs
	import o3cr_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic output_sync_req,
	input wire logic divided_clock,
	output logic divider_three_run,
	output logic divider_three_sync,
	output logic diff_driver_level,
	output logic diff_driver_hiz,
	output o3cr_std_dec_type diff_driver_mode,
	output logic third_output_true_pin,
	output logic third_output_true_pin_oe,
	output logic third_output_complement_pin,
	output logic third_output_complement_pin_oe
);
	o3cr_drv_type drv_reg;
	o3cr_drv_type drv_next;
	o3cr_se_type se_reg;
	o3cr_se_type se_next;
	logic [7:0] rdata_next;
	logic sync_reg;
	logic sync_next;
	localparam int unsigned DRV_DIFF = 0;
	localparam int unsigned DRV_TRUE = 1;
	localparam int unsigned DRV_COMP = 2;
	localparam int unsigned DRV_COUNT = 3;
	o3cr_pol_type pol_sel [DRV_COUNT];
	logic [DRV_COUNT-1:0] pol_lvl;
	o3cr_std_dec_type mode_next;
	logic run_next;
	logic lvl_next;
	logic hiz_next;
	logic tp_next;
	logic tp_oe_next;
	logic cp_next;
	logic cp_oe_next;

	function automatic o3cr_std_dec_type decode_std(input o3cr_std_type code);
		o3cr_std_dec_type d;
		d = '0;
		unique case (code)
			O3CR_STD_LVDS_HALF, O3CR_STD_LVDS_3Q, O3CR_STD_LVDS_FULL, O3CR_STD_LVDS_125: begin
				d.lvds_active = 1'b1;
				d.current_level = code[1:0];
			end
			O3CR_STD_HSTL: d.hstl_active = 1'b1;
			O3CR_STD_HSTL_BOOST: begin
				d.hstl_active = 1'b1;
				d.hstl_boost = 1'b1;
			end
			O3CR_STD_HIZ_A, O3CR_STD_HIZ_B: d.hiz_cmos = 1'b1;
		endcase
		return d;
	endfunction : decode_std

	always_comb begin
		drv_next = drv_reg;
		se_next = se_reg;
		if (reg_wr && reg_addr == O3CR_DRV_CTRL_ADDR) begin
			drv_next = o3cr_drv_type'(reg_wdata & O3CR_DRV_CTRL_WMASK);
		end
		if (reg_wr && reg_addr == O3CR_SE_CTRL_ADDR) begin
			se_next = o3cr_se_type'(reg_wdata & O3CR_SE_CTRL_WMASK);
		end
		unique case (reg_addr)
			O3CR_DRV_CTRL_ADDR: rdata_next = drv_reg;
			O3CR_SE_CTRL_ADDR: rdata_next = se_reg;
			default: rdata_next = 8'h00;
		endcase
		sync_next = output_sync_req && !drv_reg.divider_three_sync_exclude;
	end

	always_comb begin
		pol_sel[DRV_DIFF] = drv_reg.diff_driver_polarity;
		pol_sel[DRV_TRUE] = se_reg.true_side_cmos_polarity;
		pol_sel[DRV_COMP] = se_reg.comp_side_cmos_polarity;
	end

	always_comb begin
		mode_next = decode_std(drv_reg.diff_driver_standard);
		hiz_next = mode_next.hiz_cmos;
		run_next = !drv_reg.divider_three_powerdown;
		lvl_next = pol_lvl[DRV_DIFF];
		tp_next = pol_lvl[DRV_TRUE];
		tp_oe_next = se_reg.true_side_cmos_enable;
		cp_next = pol_lvl[DRV_COMP];
		cp_oe_next = se_reg.comp_side_cmos_enable;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			drv_reg <= o3cr_drv_type'(O3CR_DRV_CTRL_RESET);
			se_reg <= o3cr_se_type'(O3CR_SE_CTRL_RESET);
			reg_rdata <= 8'h00;
			sync_reg <= 1'b0;
			divider_three_run <= 1'b0;
			diff_driver_level <= 1'b0;
			diff_driver_hiz <= 1'b0;
			diff_driver_mode <= '0;
			third_output_true_pin <= 1'b0;
			third_output_true_pin_oe <= 1'b0;
			third_output_complement_pin <= 1'b0;
			third_output_complement_pin_oe <= 1'b0;
		end else begin
			drv_reg <= drv_next;
			se_reg <= se_next;
			reg_rdata <= rdata_next;
			sync_reg <= sync_next;
			divider_three_run <= run_next;
			diff_driver_level <= lvl_next;
			diff_driver_hiz <= hiz_next;
			diff_driver_mode <= mode_next;
			third_output_true_pin <= tp_next;
			third_output_true_pin_oe <= tp_oe_next;
			third_output_complement_pin <= cp_next;
			third_output_complement_pin_oe <= cp_oe_next;
		end
	end

	assign divider_three_sync = sync_reg;

	for (genvar i = 0; i < DRV_COUNT; i++) begin : g_pol
		o3cr_polarity o3cr_polarity_inst (
			.clk_div(divided_clock),
			.pol(pol_sel[i]),
			.pin_level(pol_lvl[i])
		);
	end

	a_sync_excluded: assert property (@(posedge clk) disable iff (srst)
		drv_reg.divider_three_sync_exclude |=> !divider_three_sync)
		else $error("excluded divider was synchronized");
	a_sync_passes: assert property (@(posedge clk) disable iff (srst)
		(output_sync_req && !drv_reg.divider_three_sync_exclude) |=> divider_three_sync)
		else $error("sync request not forwarded");
	a_mask_reset: assert property (@(posedge clk)
		srst |=> !drv_reg.divider_three_sync_exclude && !divider_three_sync)
		else $error("sync exclude not cleared by reset");
	a_diff_force: assert property (@(posedge clk) disable iff (srst)
		(drv_reg.diff_driver_polarity == O3CR_POL_FORCE_HIGH && $stable(drv_reg))
		|=> diff_driver_level)
		else $error("differential force high failed");
	a_diff_low: assert property (@(posedge clk) disable iff (srst)
		(drv_reg.diff_driver_polarity == O3CR_POL_FORCE_LOW) |=> !diff_driver_level)
		else $error("differential force low failed");
	a_mode_hiz: assert property (@(posedge clk) disable iff (srst)
		(drv_reg.diff_driver_standard[2:1] == 2'b11) |=> diff_driver_hiz && !diff_driver_mode.lvds_active)
		else $error("high-z code not decoded");
	a_true_enable: assert property (@(posedge clk) disable iff (srst)
		##1 third_output_true_pin_oe == $past(se_reg.true_side_cmos_enable))
		else $error("true-side enable mismatch");
	a_true_reset: assert property (@(posedge clk)
		srst |=> se_reg.true_side_cmos_polarity == O3CR_POL_FORCE_HIGH && !se_reg.true_side_cmos_enable)
		else $error("true-side reset values wrong");
	a_comp_enable: assert property (@(posedge clk) disable iff (srst)
		##1 third_output_complement_pin_oe == $past(se_reg.comp_side_cmos_enable))
		else $error("complement enable mismatch");
	a_comp_low: assert property (@(posedge clk) disable iff (srst)
		(se_reg.comp_side_cmos_polarity == O3CR_POL_FORCE_LOW) |=> !third_output_complement_pin)
		else $error("complement force low failed");
	a_powerdown_stop: assert property (@(posedge clk) disable iff (srst)
		drv_reg.divider_three_powerdown |=> !divider_three_run)
		else $error("divider ran while powered down");
	// the sampled srst guard keeps the release edge out, where outputs still hold reset values
	a_diff_pass: assert property (@(posedge clk) disable iff (srst)
		(!srst && drv_reg.diff_driver_polarity == O3CR_POL_PASS)
		|=> diff_driver_level == $past(divided_clock))
		else $error("differential pass-through failed");
	a_diff_invert: assert property (@(posedge clk) disable iff (srst)
		(!srst && drv_reg.diff_driver_polarity == O3CR_POL_INVERT)
		|=> diff_driver_level == !$past(divided_clock))
		else $error("differential inversion failed");
	a_mode_lvds: assert property (@(posedge clk) disable iff (srst)
		(!srst && !drv_reg.diff_driver_standard[2]) |=> diff_driver_mode.lvds_active
		&& diff_driver_mode.current_level == $past(drv_reg.diff_driver_standard[1:0]))
		else $error("lvds code not decoded");
	a_mode_hstl: assert property (@(posedge clk) disable iff (srst)
		(!srst && drv_reg.diff_driver_standard == O3CR_STD_HSTL)
		|=> diff_driver_mode.hstl_active && !diff_driver_mode.hstl_boost && !diff_driver_hiz)
		else $error("hstl code not decoded");
	a_mode_boost: assert property (@(posedge clk) disable iff (srst)
		(!srst && drv_reg.diff_driver_standard == O3CR_STD_HSTL_BOOST)
		|=> diff_driver_mode.hstl_active && diff_driver_mode.hstl_boost)
		else $error("boosted hstl code not decoded");
	a_true_high: assert property (@(posedge clk) disable iff (srst)
		(!srst && se_reg.true_side_cmos_polarity == O3CR_POL_FORCE_HIGH)
		|=> third_output_true_pin)
		else $error("true-side force high failed");
	a_true_low: assert property (@(posedge clk) disable iff (srst)
		(!srst && se_reg.true_side_cmos_polarity == O3CR_POL_FORCE_LOW)
		|=> !third_output_true_pin)
		else $error("true-side force low failed");
	a_true_pass: assert property (@(posedge clk) disable iff (srst)
		(!srst && se_reg.true_side_cmos_polarity == O3CR_POL_PASS)
		|=> third_output_true_pin == $past(divided_clock))
		else $error("true-side pass-through failed");
	a_true_invert: assert property (@(posedge clk) disable iff (srst)
		(!srst && se_reg.true_side_cmos_polarity == O3CR_POL_INVERT)
		|=> third_output_true_pin == !$past(divided_clock))
		else $error("true-side inversion failed");
	a_comp_high: assert property (@(posedge clk) disable iff (srst)
		(!srst && se_reg.comp_side_cmos_polarity == O3CR_POL_FORCE_HIGH)
		|=> third_output_complement_pin)
		else $error("complement force high failed");
	a_comp_pass: assert property (@(posedge clk) disable iff (srst)
		(!srst && se_reg.comp_side_cmos_polarity == O3CR_POL_PASS)
		|=> third_output_complement_pin == $past(divided_clock))
		else $error("complement pass-through failed");
	a_comp_invert: assert property (@(posedge clk) disable iff (srst)
		(!srst && se_reg.comp_side_cmos_polarity == O3CR_POL_INVERT)
		|=> third_output_complement_pin == !$past(divided_clock))
		else $error("complement inversion failed");
	a_powerdown_run: assert property (@(posedge clk) disable iff (srst)
		(!srst && !drv_reg.divider_three_powerdown)
		|=> divider_three_run)
		else $error("divider held stopped after power-down cleared");
	a_comp_reset: assert property (@(posedge clk)
		srst |=> se_reg.comp_side_cmos_polarity == O3CR_POL_FORCE_HIGH
		&& !se_reg.comp_side_cmos_enable)
		else $error("complement reset values wrong");
endmodule : o3cr_output3_control_regs

// ===== bench/o3cr_output3_control_regs_tb_top.sv
`timescale 1ns/1ps
module o3cr_output3_control_regs_tb_top;
	import o3cr_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic reg_wr = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic output_sync_req = 1'b0;
	logic divided_clock = 1'b0;
	logic [7:0] reg_rdata;
	logic run, sync, lvl, hiz, tp, tp_oe, cp, cp_oe;
	o3cr_std_dec_type mode;
	int error_cnt = 0;
	int n_tests = 0;
	always #2 clk = ~clk;
	o3cr_output3_control_regs o3cr_output3_control_regs_inst (.clk(clk), .srst(srst),
		.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.output_sync_req(output_sync_req), .divided_clock(divided_clock),
		.divider_three_run(run), .divider_three_sync(sync), .diff_driver_level(lvl),
		.diff_driver_hiz(hiz), .diff_driver_mode(mode), .third_output_true_pin(tp),
		.third_output_true_pin_oe(tp_oe), .third_output_complement_pin(cp),
		.third_output_complement_pin_oe(cp_oe));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		repeat (2) @(posedge clk);
		#1;
		chk("reg_rdata", e, reg_rdata);
	endtask : rd
	task automatic t_regs();
		rd(O3CR_SE_CTRL_ADDR, 8'h00);
		rd(O3CR_DRV_CTRL_ADDR, 8'h14);
		chk("true_oe", 8'h00, {7'h0, tp_oe});
		chk("comp_oe", 8'h00, {7'h0, cp_oe});
		wr(8'h30, 8'hff);
		rd(8'h30, 8'h00);
		wr(O3CR_SE_CTRL_ADDR, 8'hfc);
		rd(O3CR_SE_CTRL_ADDR, 8'hfc);
		wr(O3CR_SE_CTRL_ADDR, 8'he4);
		chk("true_pin", 8'h02, {6'h0, tp_oe, tp});
		chk("comp_oe", 8'h00, {7'h0, cp_oe});
		wr(O3CR_SE_CTRL_ADDR, 8'h9c);
		chk("comp_pin", 8'h02, {6'h0, cp_oe, cp});
		chk("true_pin", 8'h03, {6'h0, tp_oe, tp});
	endtask : t_regs
	task automatic t_sync(input logic excl);
		wr(O3CR_DRV_CTRL_ADDR, {1'b0, excl, 6'h14});
		@(posedge clk);
		output_sync_req <= 1'b1;
		@(posedge clk);
		output_sync_req <= 1'b0;
		#1;
		chk("sync", {7'h0, ~excl}, {7'h0, sync});
	endtask : t_sync
	task automatic t_pol();
		logic e;
		for (int d = 0; d < 2; d++) begin
			for (int p = 0; p < 4; p++) begin
				e = (p == 0) ? 1'b1 : (p == 3) ? 1'b0 : (p == 1) ? d[0] : ~d[0];
				@(posedge clk);
				divided_clock <= d[0];
				wr(O3CR_DRV_CTRL_ADDR, {2'b00, p[1:0], 3'b010, 1'b0});
				chk("diff_level", {7'h0, e}, {7'h0, lvl});
			end
		end
	endtask : t_pol
	task automatic t_std();
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			wr(O3CR_DRV_CTRL_ADDR, {4'h1, c, 1'b0});
			chk("hiz", {7'h0, c[2] & c[1]}, {7'h0, hiz});
			chk("mode", {5'h0, ~c[2], c[2] & ~c[1], c[2] & c[1]},
				{5'h0, mode.lvds_active, mode.hstl_active, mode.hiz_cmos});
			if (!c[2])
				chk("level", {6'h0, c[1:0]}, {6'h0, mode.current_level});
			chk("boost", {7'h0, c == 3'b101}, {7'h0, mode.hstl_boost});
		end
	endtask : t_std
	task automatic t_pd();
		wr(O3CR_DRV_CTRL_ADDR, 8'h94);
		chk("run", 8'h00, {7'h0, run});
		wr(O3CR_DRV_CTRL_ADDR, 8'h14);
		chk("run", 8'h01, {7'h0, run});
	endtask : t_pd
	task automatic test_done();
		$display("errors %0d comparisons %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	initial begin
		#200000;
		error_cnt++;
		test_done();
	end
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		t_regs();
		t_sync(1'b0);
		t_sync(1'b1);
		t_pol();
		t_std();
		t_pd();
		test_done();
	end
endmodule : o3cr_output3_control_regs_tb_top
